// ===== src/bpc_regs.sv
// Serial-bus register bank for the backup power manager control fields
`timescale 1ns/10ps
`include "bpc_defines.svh"

// Overview of operation
// - Limit source bit 0 picks internal limit, 1 picks the pin resistor; resets 0.
// - Three-bit field picks release switching frequency; resets to 480kHz code.
// - Writing 1 to forced-release puts the device into step-down release mode.
// - After forced-release clears, release mode holds until bus undervoltage lockout.
// - Three-bit field picks internal input current threshold; resets to 000.
// - Two-bit field sets bus voltage ramp-up rate; resets to 00.
// - Two-bit field sets power-on-reset delay when the delay pin floats.
// - Enable bit turns device on at 1, off at 0; resets to 1.
// - Enable writes ignored in release mode unless undervoltage lockout is present.
// - Limiter-disable 1 switches off isolation transistor limiting; resets 0.
// - Over-current status flag still sets while limiting is disabled.
// - Three-bit tune field trims the selected limit by 0, -2, +2, -4, +4 percent.
module bpc_regs #(
    parameter logic [6:0] DEV_ADDR = `BPC_I2C_ADDR
) (
    input  wire logic                clock,
    input  wire logic                nrst,
    input  wire logic                clk_en,
    input  wire logic                scl_in,
    input  wire logic                sda_in,
    output logic                     sda_out,
    output logic                     sda_oe_n,
    input  wire logic                power_fail,
    input  wire logic                bus_undervoltage_lockout,
    input  wire logic                oc_event,
    input  wire logic                oc_clear,
    output bpc_pkg::bpc_ctl_out_type ctl,
    output logic                     release_mode,
    output logic                     limit_active,
    output logic                     oc_status
);
    import bpc_pkg::*;

    bpc_main_st_type s_ff;
    bpc_main_st_type nxt_s;
    logic            scl_rise;
    logic            scl_fall;
    logic            start_cond;
    logic            stop_cond;
    logic            enable_writable;
    logic [7:0]      rd_data;
    logic [7:0]      wr_byte;

    // Bus sequences are seen on the sampled pins, one clock apart
    assign scl_rise   = scl_in && !s_ff.scl_q;
    assign scl_fall   = !scl_in && s_ff.scl_q;
    assign start_cond = scl_in && s_ff.scl_q && s_ff.sda_q && !sda_in;
    assign stop_cond  = scl_in && s_ff.scl_q && !s_ff.sda_q && sda_in;
    assign wr_byte    = s_ff.shreg;

    // Read view; undefined bits and unmapped offsets return zero
    always_comb begin
        rd_data = 8'h00;
        case (s_ff.ptr)
            `BPC_OFS_CTL_TWO: begin
                rd_data[`BPC_SRC_BIT]                 = s_ff.cfg.src_sel;
                rd_data[`BPC_FSW_MSB:`BPC_FSW_LSB]    = s_ff.cfg.fsw;
                rd_data[`BPC_FORCE_BIT]               = s_ff.cfg.force_rel;
            end
            `BPC_OFS_CTL_THREE: begin
                rd_data[`BPC_LIM_MSB:`BPC_LIM_LSB]    = s_ff.cfg.lim;
                rd_data[`BPC_SLEW_MSB:`BPC_SLEW_LSB]  = s_ff.cfg.slew;
                rd_data[`BPC_DLY_MSB:`BPC_DLY_LSB]    = s_ff.cfg.dly;
                rd_data[`BPC_EN_BIT]                  = s_ff.cfg.en;
            end
            `BPC_OFS_CTL_FOUR: begin
                rd_data[`BPC_LDIS_BIT]                = s_ff.cfg.ldis;
                rd_data[`BPC_TUNE_MSB:`BPC_TUNE_LSB]  = s_ff.cfg.tune;
            end
            default: begin
                rd_data = 8'h00;
            end
        endcase
    end

    always_comb begin
        nxt_s       = s_ff;
        nxt_s.scl_q = scl_in;
        nxt_s.sda_q = sda_in;
        if (start_cond) begin
            nxt_s.st  = ST_ADDR;
            nxt_s.cnt = 4'h0;
            nxt_s.drv = 1'b0;
        end else if (stop_cond) begin
            nxt_s.st  = ST_IDLE;
            nxt_s.drv = 1'b0;
        end else begin
            case (s_ff.st)
                ST_IDLE: begin
                    nxt_s.drv = 1'b0;
                end
                ST_ADDR, ST_REG, ST_WDATA: begin
                    if (scl_rise) begin
                        nxt_s.shreg = {s_ff.shreg[6:0], sda_in};
                        nxt_s.cnt   = s_ff.cnt + 4'h1;
                    end else if (scl_fall && s_ff.cnt == `BPC_BYTE_BITS) begin
                        nxt_s.cnt = 4'h0;
                        nxt_s.drv = 1'b1;
                        if (s_ff.st == ST_ADDR) begin
                            if (s_ff.shreg[7:1] == DEV_ADDR) begin
                                nxt_s.rw = s_ff.shreg[0];
                                nxt_s.st = ST_ACK_ADDR;
                            end else begin
                                nxt_s.drv = 1'b0;
                                nxt_s.st  = ST_IDLE;
                            end
                        end else if (s_ff.st == ST_REG) begin
                            nxt_s.ptr = s_ff.shreg;
                            nxt_s.st  = ST_ACK_REG;
                        end else begin
                            nxt_s.st = ST_ACK_W;
                            case (s_ff.ptr)
                                `BPC_OFS_CTL_TWO: begin
                                    nxt_s.cfg.src_sel   = wr_byte[`BPC_SRC_BIT];
                                    nxt_s.cfg.fsw       =
                                        wr_byte[`BPC_FSW_MSB:`BPC_FSW_LSB];
                                    nxt_s.cfg.force_rel = wr_byte[`BPC_FORCE_BIT];
                                end
                                `BPC_OFS_CTL_THREE: begin
                                    nxt_s.cfg.lim  =
                                        wr_byte[`BPC_LIM_MSB:`BPC_LIM_LSB];
                                    nxt_s.cfg.slew =
                                        wr_byte[`BPC_SLEW_MSB:`BPC_SLEW_LSB];
                                    nxt_s.cfg.dly  =
                                        wr_byte[`BPC_DLY_MSB:`BPC_DLY_LSB];
                                    if (enable_writable) begin
                                        nxt_s.cfg.en = wr_byte[`BPC_EN_BIT];
                                    end
                                end
                                `BPC_OFS_CTL_FOUR: begin
                                    nxt_s.cfg.ldis = wr_byte[`BPC_LDIS_BIT];
                                    nxt_s.cfg.tune =
                                        wr_byte[`BPC_TUNE_MSB:`BPC_TUNE_LSB];
                                end
                                default: begin
                                    nxt_s.cfg = s_ff.cfg;
                                end
                            endcase
                        end
                    end
                end
                ST_ACK_ADDR: begin
                    if (scl_fall) begin
                        if (s_ff.rw) begin
                            nxt_s.shreg = rd_data;
                            nxt_s.drv   = !rd_data[7];
                            nxt_s.st    = ST_RDATA;
                        end else begin
                            nxt_s.drv = 1'b0;
                            nxt_s.st  = ST_REG;
                        end
                    end
                end
                ST_ACK_REG, ST_ACK_W: begin
                    if (scl_fall) begin
                        nxt_s.drv = 1'b0;
                        nxt_s.st  = ST_WDATA;
                        if (s_ff.st == ST_ACK_W) begin
                            nxt_s.ptr = s_ff.ptr + 8'h01;
                        end
                    end
                end
                ST_RDATA: begin
                    if (scl_rise) begin
                        nxt_s.cnt = s_ff.cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (s_ff.cnt == `BPC_BYTE_BITS) begin
                            nxt_s.cnt = 4'h0;
                            nxt_s.drv = 1'b0;
                            nxt_s.st  = ST_ACK_R;
                        end else begin
                            nxt_s.shreg = {s_ff.shreg[6:0], 1'b0};
                            nxt_s.drv   = !s_ff.shreg[6];
                        end
                    end
                end
                ST_ACK_R: begin
                    // Host acknowledge moves on to the next register, a refusal ends the read
                    if (scl_rise) begin
                        if (sda_in) begin
                            nxt_s.st = ST_IDLE;
                        end else begin
                            nxt_s.ptr = s_ff.ptr + 8'h01;
                        end
                    end else if (scl_fall) begin
                        nxt_s.shreg = rd_data;
                        nxt_s.drv   = !rd_data[7];
                        nxt_s.st    = ST_RDATA;
                    end
                end
                default: begin
                    nxt_s.st  = ST_IDLE;
                    nxt_s.drv = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_ff.st            <= ST_IDLE;
            s_ff.shreg         <= 8'h00;
            s_ff.cnt           <= 4'h0;
            s_ff.ptr           <= 8'h00;
            s_ff.rw            <= 1'b0;
            s_ff.drv           <= 1'b0;
            s_ff.scl_q         <= 1'b1;
            s_ff.sda_q         <= 1'b1;
            s_ff.cfg.src_sel   <= `BPC_RST_SRC;
            s_ff.cfg.fsw       <= `BPC_RST_FSW;
            s_ff.cfg.force_rel <= `BPC_RST_FORCE;
            s_ff.cfg.lim       <= `BPC_RST_LIM;
            s_ff.cfg.slew      <= `BPC_RST_SLEW;
            s_ff.cfg.dly       <= `BPC_RST_DLY;
            s_ff.cfg.en        <= `BPC_RST_EN;
            s_ff.cfg.ldis      <= `BPC_RST_LDIS;
            s_ff.cfg.tune      <= `BPC_RST_TUNE;
        end else if (clk_en) begin
            s_ff <= nxt_s;
        end
    end

    bpc_release_ctl u_release (
        .clock                    (clock),
        .nrst                     (nrst),
        .clk_en                   (clk_en),
        .force_rel                (s_ff.cfg.force_rel),
        .power_fail               (power_fail),
        .bus_undervoltage_lockout (bus_undervoltage_lockout),
        .oc_event                 (oc_event),
        .oc_clear                 (oc_clear),
        .release_mode             (release_mode),
        .enable_writable          (enable_writable),
        .oc_status                (oc_status)
    );

    // Open drain: only ever pulls low
    assign sda_out  = 1'b0;
    assign sda_oe_n = !s_ff.drv;

    always_comb begin
        ctl.limit_source_select  = s_ff.cfg.src_sel;
        ctl.internal_limit_level = s_ff.cfg.lim;
        ctl.switch_freq          = s_ff.cfg.fsw;
        ctl.bus_ramp_slew        = s_ff.cfg.slew;
        ctl.reset_delay_select   = s_ff.cfg.dly;
        ctl.device_enable        = s_ff.cfg.en;
        ctl.limiter_disable      = s_ff.cfg.ldis;
        ctl.limit_fine_tune      = (s_ff.cfg.tune > `BPC_TUNE_MAX) ? `BPC_TUNE_NONE
                                                                   : s_ff.cfg.tune;
    end

    assign limit_active = !s_ff.cfg.ldis;

endmodule : bpc_regs

// ===== src/bpc_defines.svh
// Offsets, field positions, reset values and constants of the backup power control registers
`ifndef BPC_DEFINES_SVH
`define BPC_DEFINES_SVH

`define BPC_OFS_CTL_TWO    8'h20
`define BPC_OFS_CTL_THREE  8'h21
`define BPC_OFS_CTL_FOUR   8'h22

`define BPC_SRC_BIT        6
`define BPC_FSW_MSB        3
`define BPC_FSW_LSB        1
`define BPC_FORCE_BIT      0
`define BPC_LIM_MSB        7
`define BPC_LIM_LSB        5
`define BPC_SLEW_MSB       4
`define BPC_SLEW_LSB       3
`define BPC_DLY_MSB        2
`define BPC_DLY_LSB        1
`define BPC_EN_BIT         0
`define BPC_LDIS_BIT       3
`define BPC_TUNE_MSB       2
`define BPC_TUNE_LSB       0

`define BPC_RST_SRC        1'h0
`define BPC_RST_FSW        3'h4
`define BPC_RST_FORCE      1'h0
`define BPC_RST_LIM        3'h0
`define BPC_RST_SLEW       2'h0
`define BPC_RST_DLY        2'h0
`define BPC_RST_EN         1'h1
`define BPC_RST_LDIS       1'h0
`define BPC_RST_TUNE       3'h0

`define BPC_TUNE_MAX       3'h4
`define BPC_TUNE_NONE      3'h0
`define BPC_BYTE_BITS      4'h8
`define BPC_I2C_ADDR       7'h60

`endif

// ===== src/bpc_pkg.sv
// Types shared by the backup power control register bank
package bpc_pkg;

    typedef enum logic [8:0] {
        ST_IDLE     = 9'h001,
        ST_ADDR     = 9'h002,
        ST_ACK_ADDR = 9'h004,
        ST_REG      = 9'h008,
        ST_ACK_REG  = 9'h010,
        ST_WDATA    = 9'h020,
        ST_ACK_W    = 9'h040,
        ST_RDATA    = 9'h080,
        ST_ACK_R    = 9'h100
    } bpc_i2c_st_type;

    typedef struct packed {
        logic       src_sel;
        logic [2:0] fsw;
        logic       force_rel;
        logic [2:0] lim;
        logic [1:0] slew;
        logic [1:0] dly;
        logic       en;
        logic       ldis;
        logic [2:0] tune;
    } bpc_cfg_type;

    typedef struct packed {
        bpc_i2c_st_type st;
        logic [7:0]     shreg;
        logic [3:0]     cnt;
        logic [7:0]     ptr;
        logic           rw;
        logic           drv;
        logic           scl_q;
        logic           sda_q;
        bpc_cfg_type    cfg;
    } bpc_main_st_type;

    typedef struct packed {
        logic release_mode;
        logic oc_flag;
    } bpc_rel_st_type;

    typedef struct packed {
        logic       limit_source_select;
        logic [2:0] internal_limit_level;
        logic [2:0] switch_freq;
        logic [1:0] bus_ramp_slew;
        logic [1:0] reset_delay_select;
        logic       device_enable;
        logic       limiter_disable;
        logic [2:0] limit_fine_tune;
    } bpc_ctl_out_type;

endpackage : bpc_pkg

// ===== src/bpc_release_ctl.sv
// Step-down release latch and input over-current status flag
`timescale 1ns/10ps
`include "bpc_defines.svh"

module bpc_release_ctl (
    input  wire logic clock,
    input  wire logic nrst,
    input  wire logic clk_en,
    input  wire logic force_rel,
    input  wire logic power_fail,
    input  wire logic bus_undervoltage_lockout,
    input  wire logic oc_event,
    input  wire logic oc_clear,
    output logic      release_mode,
    output logic      enable_writable,
    output logic      oc_status
);
    import bpc_pkg::*;

    bpc_rel_st_type s_ff;
    bpc_rel_st_type nxt_s;

    always_comb begin
        nxt_s = s_ff;
        if (force_rel || power_fail) begin
            nxt_s.release_mode = 1'b1;
        end else if (bus_undervoltage_lockout) begin
            nxt_s.release_mode = 1'b0;
        end
        // Flag is set whether or not limiting is active; set beats clear
        if (oc_event) begin
            nxt_s.oc_flag = 1'b1;
        end else if (oc_clear) begin
            nxt_s.oc_flag = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_ff <= '0;
        end else if (clk_en) begin
            s_ff <= nxt_s;
        end
    end

    assign release_mode    = s_ff.release_mode;
    assign enable_writable = !s_ff.release_mode || bus_undervoltage_lockout;
    assign oc_status       = s_ff.oc_flag;

endmodule : bpc_release_ctl

// ===== test/bpc_regs_asserts.sv
// Port checks for the backup power control register bank
`timescale 1ns/10ps
module bpc_regs_asserts (
    input wire logic                     clock,
    input wire logic                     nrst,
    input wire logic                     clk_en,
    input wire logic                     scl_in,
    input wire logic                     sda_in,
    input wire logic                     sda_out,
    input wire logic                     sda_oe_n,
    input wire logic                     power_fail,
    input wire logic                     bus_undervoltage_lockout,
    input wire logic                     oc_event,
    input wire logic                     oc_clear,
    input wire bpc_pkg::bpc_ctl_out_type ctl,
    input wire logic                     release_mode,
    input wire logic                     limit_active,
    input wire logic                     oc_status
);
    import bpc_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence s_lock_window;
        release_mode && !bus_undervoltage_lockout;
    endsequence
    sequence s_ack_drive;
        $fell(sda_oe_n);
    endsequence
    sequence s_level_move;
        $changed(ctl.internal_limit_level);
    endsequence

    a_reset_values: assert property ($rose(nrst) |-> ctl == 16'h0810 && !oc_status)
        else $error("control fields off their reset values");
    a_release_hold: assert property (s_lock_window |=> release_mode)
        else $error("release mode left without lockout");
    a_power_entry: assert property (clk_en && power_fail |=> release_mode)
        else $error("power loss did not enter release mode");
    a_enable_locked: assert property (s_lock_window |=> $stable(ctl.device_enable))
        else $error("enable changed in release mode");
    a_slew_on_ack: assert property ($changed(ctl.bus_ramp_slew) |-> s_ack_drive)
        else $error("ramp slew changed outside a data acknowledge");
    a_level_on_ack: assert property (s_level_move |-> s_ack_drive)
        else $error("limit level changed outside a data acknowledge");
    a_limit_follow: assert property (limit_active == !ctl.limiter_disable)
        else $error("limit active disagrees with limiter disable");
    a_tune_range: assert property (ctl.limit_fine_tune <= 3'h4)
        else $error("undefined fine tune code reached the output");
    a_oc_sets: assert property (clk_en && oc_event |=> oc_status)
        else $error("over-current flag not set");
    a_oc_sticky: assert property (oc_status && !oc_clear |=> oc_status)
        else $error("over-current flag dropped without clear");
    a_oc_clears: assert property (clk_en && oc_clear && !oc_event |=> !oc_status)
        else $error("over-current flag not cleared");
endmodule : bpc_regs_asserts

bind bpc_regs bpc_regs_asserts u_bpc_chk (
    .clock(clock), .nrst(nrst), .clk_en(clk_en), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .power_fail(power_fail),
    .bus_undervoltage_lockout(bus_undervoltage_lockout), .oc_event(oc_event),
    .oc_clear(oc_clear), .ctl(ctl), .release_mode(release_mode),
    .limit_active(limit_active), .oc_status(oc_status)
);

// ===== test/bpc_host_model.sv
// Serial-bus host model that reads and writes the control registers
`timescale 1ns/10ps
module bpc_host_model (
    input  wire logic clock,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_drv
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic quarter();
        repeat (2) @(negedge clock);
    endtask : quarter
    task automatic send_bit(input logic b);
        sda_drv = b;
        quarter();
        scl = 1'b1;
        quarter();
        quarter();
        scl = 1'b0;
        quarter();
    endtask : send_bit
    task automatic get_bit(output logic b);
        sda_drv = 1'b1;
        quarter();
        scl = 1'b1;
        quarter();
        b = sda_line;
        quarter();
        scl = 1'b0;
        quarter();
    endtask : get_bit
    task automatic start();
        sda_drv = 1'b1;
        quarter();
        scl = 1'b1;
        quarter();
        sda_drv = 1'b0;
        quarter();
        scl = 1'b0;
        quarter();
    endtask : start
    task automatic stop();
        sda_drv = 1'b0;
        quarter();
        scl = 1'b1;
        quarter();
        sda_drv = 1'b1;
        quarter();
    endtask : stop
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic nak;
        for (int i = 7; i >= 0; i--) send_bit(b[i]);
        get_bit(nak);
        ack = (nak === 1'b0);
    endtask : put_byte
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] ofs,
                             input logic [7:0] dat, output logic ok);
        logic a0, a1, a2;
        a1 = 1'b0;
        a2 = 1'b0;
        start();
        put_byte({dev, 1'b0}, a0);
        if (a0) begin
            put_byte(ofs, a1);
            put_byte(dat, a2);
        end
        stop();
        ok = a0 && a1 && a2;
    endtask : write_reg
    task automatic read_reg(input logic [6:0] dev, input logic [7:0] ofs,
                            output logic [7:0] dat, output logic ok);
        logic a0, a1, a2;
        start();
        put_byte({dev, 1'b0}, a0);
        put_byte(ofs, a1);
        start();
        put_byte({dev, 1'b1}, a2);
        for (int i = 7; i >= 0; i--) get_bit(dat[i]);
        send_bit(1'b1);
        stop();
        ok = a0 && a1 && a2;
    endtask : read_reg
endmodule : bpc_host_model

// ===== test/bpc_regs_test.sv
// Self-checking bench for the backup power control register bank
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin mismatches++; \
    $display("unexpected %s: expected %h seen %h", nm, exp, got); end end
module bpc_regs_test;
    import bpc_pkg::*;
    localparam logic [6:0] DEV = 7'h5A; // Arbitrary bus address
    logic clock, nrst, clk_en, power_fail, lockout, oc_event, oc_clear;
    logic scl, host_sda, sda_line, sda_out, sda_oe_n, release_mode, limit_active, oc_status;
    logic ok;
    logic [2:0] c;
    bpc_ctl_out_type ctl;
    int mismatches = 0;
    int tests_run = 0;

    // Pull-up: the line is low only while someone pulls it
    assign sda_line = host_sda & (sda_oe_n | sda_out);
    initial clock = 1'b0;
    always #12.5 clock = ~clock;

    bpc_regs #(.DEV_ADDR(DEV)) dut (
        .clock(clock), .nrst(nrst), .clk_en(clk_en), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .power_fail(power_fail),
        .bus_undervoltage_lockout(lockout), .oc_event(oc_event), .oc_clear(oc_clear),
        .ctl(ctl), .release_mode(release_mode), .limit_active(limit_active),
        .oc_status(oc_status)
    );
    bpc_host_model host (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_drv(host_sda));

    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask : tick
    task automatic wr(input logic [7:0] ofs, input logic [7:0] dat);
        logic ack;
        host.write_reg(DEV, ofs, dat, ack);
        `CHK("write ack", 1'b1, ack)
    endtask : wr
    task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
        logic [7:0] d;
        logic ack;
        host.read_reg(DEV, ofs, d, ack);
        `CHK("read ack", 1'b1, ack)
        `CHK("read data", exp, d)
    endtask : rd
    task automatic check_defaults();
        `CHK("ctl", 16'h0810, ctl)
        `CHK("sda released", 1'b1, sda_oe_n)
        rd(8'h20, 8'h08);
        rd(8'h21, 8'h01);
        rd(8'h22, 8'h00);
        rd(8'h23, 8'h00);
        `CHK("release", 1'b0, release_mode)
        `CHK("limit active", 1'b1, limit_active)
        `CHK("oc flag", 1'b0, oc_status)
    endtask : check_defaults
    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (60000) @(posedge clock);
        mismatches++;
        tally_and_finish();
    end

    initial begin
        nrst = 1'b0;
        clk_en = 1'b1;
        power_fail = 1'b0;
        lockout = 1'b0;
        oc_event = 1'b0;
        oc_clear = 1'b0;
        tick(20);
        nrst = 1'b1;
        tick(2);
        check_defaults();
        host.write_reg(7'h11, 8'h21, 8'h00, ok);
        `CHK("foreign ack", 1'b0, ok)
        `CHK("enable kept", 1'b1, ctl.device_enable)
        for (int i = 0; i < 8; i++) begin
            c = i[2:0];
            wr(8'h20, {1'b1, c[0], 2'b11, c, 1'b0});
            rd(8'h20, {1'b0, c[0], 2'b00, c, 1'b0});
            `CHK("frequency", c, ctl.switch_freq)
            `CHK("limit source", c[0], ctl.limit_source_select)
            wr(8'h21, {c, c[1:0], ~c[1:0], 1'b1});
            rd(8'h21, {c, c[1:0], ~c[1:0], 1'b1});
            `CHK("limit level", c, ctl.internal_limit_level)
            `CHK("ramp slew", c[1:0], ctl.bus_ramp_slew)
            `CHK("reset delay", ~c[1:0], ctl.reset_delay_select)
            wr(8'h22, {4'hA, c[0], c});
            rd(8'h22, {4'h0, c[0], c});
            `CHK("fine tune", (c > 3'h4) ? 3'h0 : c, ctl.limit_fine_tune)
            `CHK("limit active", ~c[0], limit_active)
            `CHK("limiter disable", c[0], ctl.limiter_disable)
            `CHK("no release", 1'b0, release_mode)
        end
        wr(8'h20, 8'h09);
        `CHK("forced release", 1'b1, release_mode)
        wr(8'h20, 8'h08);
        `CHK("release held", 1'b1, release_mode)
        wr(8'h21, 8'h00);
        rd(8'h21, 8'h01);
        lockout = 1'b1;
        tick(2);
        `CHK("release ended", 1'b0, release_mode)
        wr(8'h21, 8'h00);
        `CHK("device off", 1'b0, ctl.device_enable)
        lockout = 1'b0;
        wr(8'h21, 8'h01);
        `CHK("device on", 1'b1, ctl.device_enable)
        power_fail = 1'b1;
        tick(1);
        power_fail = 1'b0;
        tick(3);
        `CHK("power loss release", 1'b1, release_mode)
        lockout = 1'b1;
        tick(2);
        `CHK("lockout exit", 1'b0, release_mode)
        lockout = 1'b0;
        wr(8'h22, 8'h08);
        oc_event = 1'b1;
        tick(1);
        oc_event = 1'b0;
        tick(5);
        `CHK("oc flag set", 1'b1, oc_status)
        oc_clear = 1'b1;
        tick(1);
        oc_clear = 1'b0;
        tick(1);
        `CHK("oc flag cleared", 1'b0, oc_status)
        clk_en = 1'b0;
        oc_event = 1'b1;
        tick(2);
        `CHK("frozen oc flag", 1'b0, oc_status)
        oc_event = 1'b0;
        clk_en = 1'b1;
        tick(1);
        wr(8'h30, 8'hFF);
        rd(8'h30, 8'h00);
        nrst = 1'b0;
        tick(3);
        nrst = 1'b1;
        tick(2);
        check_defaults();
        tally_and_finish();
    end
endmodule : bpc_regs_test
